/* File: shared/cau_pkg.sv */
// Purpose: shared constants and types for the core alu instruction subset
// Assumes: 8-bit data path, two 16-bit indirect pointers
// Notes:   widths, offsets, field positions and the accumulator, pointer and byte reset values live here
package cau_pkg;

  // instruction selector driven by the decoder
  typedef enum logic [2:0] {
    op_pointer_offset_add,
    op_and_immediate,
    op_add_immediate,
    op_and_with_file,
    op_add_with_file,
    op_arith_shift_right,
    op_add_with_carry_file,
    op_bit_clear_in_file
  } cau_op_type;

  // widths and field positions
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned PTR_W       = 16;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned OFS_W       = 6;
  localparam int unsigned OFS_SIGN    = 5;
  localparam int unsigned PTR_MSB     = 15;
  localparam int unsigned NIB_MSB     = 3;

  // file addresses that stand for the indirect operand of each pointer
  localparam logic [6:0]  IND0_ADDR   = 7'h00;
  localparam logic [6:0]  IND1_ADDR   = 7'h01;

  // values after reset
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [15:0] PTR_RST     = 16'h0000;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;

  // extra cycles taken by an indirect access with pointer msb set
  localparam int unsigned EXTRA_CYC   = 1;

  // sign-extend the 6-bit pointer offset to pointer width
  function automatic logic [15:0] sext_offset(input logic [5:0] k);
    sext_offset = {{(PTR_W - OFS_W){k[OFS_SIGN]}}, k};
  endfunction : sext_offset

endpackage : cau_pkg

/* File: shared/cau_alu_if.sv */
// Purpose: carries operands and results between control and alu unit
// Assumes: purely combinational alu on the far side
// Notes:   one instance inside the top module
`timescale 1ns/1ps
interface cau_alu_if;
  cau_pkg::cau_op_type op;
  logic [7:0]          a;
  logic [7:0]          b;
  logic                cin;
  logic [2:0]          bit_idx;
  logic [7:0]          result;
  logic                carry;
  logic                half;
  logic                zero;

  modport alu  (input op, a, b, cin, bit_idx, output result, carry, half, zero);
  modport ctl  (output op, a, b, cin, bit_idx, input result, carry, half, zero);
endinterface : cau_alu_if

/* File: verilog/cau_alu_unit.sv */
// Purpose: combinational result and flag generation for the subset
// Assumes: operands already selected by the control module
// Notes:   flag update masks are decided by the caller
`timescale 1ns/1ps
module cau_alu_unit (
  cau_alu_if.alu       alu
);

  // 9-bit add used for the full byte and again for the low nibble
  function automatic logic [8:0] add9(input logic [7:0] x, input logic [7:0] y, input logic c);
    add9 = {1'b0, x} + {1'b0, y} + {8'h00, c};
  endfunction : add9

  wire [8:0] sum_full  = add9(alu.a, alu.b, alu.cin);
  wire [8:0] sum_nib   = add9({4'h0, alu.a[3:0]}, {4'h0, alu.b[3:0]}, alu.cin);
  wire [7:0] clr_mask  = ~(8'h01 << alu.bit_idx);
  wire [7:0] asr_val   = {alu.a[7], alu.a[7:1]};

  // result select
  always_comb begin
    alu.result = cau_pkg::ZERO_BYTE;
    alu.carry  = 1'b0;
    alu.half   = 1'b0;
    case (alu.op)
      cau_pkg::op_and_immediate,
      cau_pkg::op_and_with_file:       alu.result = alu.a & alu.b;
      cau_pkg::op_add_immediate,
      cau_pkg::op_add_with_file,
      cau_pkg::op_add_with_carry_file: begin
        alu.result = sum_full[7:0];
        alu.carry  = sum_full[8];
        alu.half   = sum_nib[cau_pkg::NIB_MSB + 1];
      end
      cau_pkg::op_arith_shift_right:   begin
        alu.result = asr_val;
        alu.carry  = alu.a[0];
      end
      cau_pkg::op_bit_clear_in_file:   alu.result = alu.a & clr_mask;
      default:                         alu.result = cau_pkg::ZERO_BYTE;
    endcase
  end

  // null-result flag
  assign alu.zero = (alu.result == cau_pkg::ZERO_BYTE);

endmodule : cau_alu_unit

/* File: verilog/cau_alu_top.sv */
// Purpose: executes the alu instruction subset on w, file data and pointers
// Assumes: decoder and data memory on the same clock; file read is combinational
// Notes:   one instruction per cycle, two when an indirect access needs the extra cycle
`timescale 1ns/1ps
module cau_alu_top (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                srst,
  // decoder request
  input  wire logic                op_valid,
  output logic                     op_ready,
  input  wire cau_pkg::cau_op_type op_code,
  input  wire logic [7:0]          op_literal,
  input  wire logic [6:0]          op_file_addr,
  input  wire logic [2:0]          op_bit_idx,
  input  wire logic                op_dest_sel,
  input  wire logic                op_ptr_sel,
  // data memory
  output logic [6:0]               file_rd_addr,
  input  wire logic [7:0]          file_rdata,
  output logic                     file_we,
  output logic [6:0]               file_waddr,
  output logic [7:0]               file_wdata,
  // architectural state
  output logic [7:0]               accum,
  output logic [15:0]              indirect_pointer0,
  output logic [15:0]              indirect_pointer1,
  output logic                     carry_bit,
  output logic                     half_byte_overflow_bit,
  output logic                     zero_bit,
  output logic                     op_done
);

  cau_alu_if alu_bus ();

  cau_alu_unit u_alu (
    .alu (alu_bus.alu)
  );

  // state registers
  logic [7:0]          acc_reg;
  logic [15:0]         ptr0_reg;
  logic [15:0]         ptr1_reg;
  logic                c_reg;
  logic                dc_reg;
  logic                z_reg;
  logic                stall_reg;
  logic                we_reg;
  logic [6:0]          waddr_reg;
  logic [7:0]          wdata_reg;
  logic                done_reg;
  cau_pkg::cau_op_type hold_op_reg;
  logic [7:0]          hold_lit_reg;
  logic [6:0]          hold_addr_reg;
  logic [2:0]          hold_bit_reg;
  logic                hold_dest_reg;
  logic                hold_psel_reg;

  // current instruction fields, held ones during the extra cycle
  cau_pkg::cau_op_type x_op;
  wire [7:0]  x_lit   = stall_reg ? hold_lit_reg  : op_literal;
  wire [6:0]  x_addr  = stall_reg ? hold_addr_reg : op_file_addr;
  wire [2:0]  x_bit   = stall_reg ? hold_bit_reg  : op_bit_idx;
  wire        x_dest  = stall_reg ? hold_dest_reg : op_dest_sel;
  wire        x_psel  = stall_reg ? hold_psel_reg : op_ptr_sel;
  assign x_op = stall_reg ? hold_op_reg : op_code;

  // instruction class decode
  wire is_ptr   = (x_op == cau_pkg::op_pointer_offset_add);
  wire is_imm   = (x_op == cau_pkg::op_and_immediate) || (x_op == cau_pkg::op_add_immediate);
  wire is_file  = !is_ptr && !is_imm;
  wire is_bclr  = (x_op == cau_pkg::op_bit_clear_in_file);
  wire is_asr   = (x_op == cau_pkg::op_arith_shift_right);
  wire is_and   = (x_op == cau_pkg::op_and_immediate) || (x_op == cau_pkg::op_and_with_file);
  wire is_add   = (x_op == cau_pkg::op_add_immediate) || (x_op == cau_pkg::op_add_with_file)
                  || (x_op == cau_pkg::op_add_with_carry_file);

  // extra cycle when an indirect operand is reached through a high pointer
  wire hit_ind0    = (x_addr == cau_pkg::IND0_ADDR) && ptr0_reg[cau_pkg::PTR_MSB];
  wire hit_ind1    = (x_addr == cau_pkg::IND1_ADDR) && ptr1_reg[cau_pkg::PTR_MSB];
  wire needs_extra = op_valid && !stall_reg && is_file && (hit_ind0 || hit_ind1);
  wire exec        = stall_reg || (op_valid && !needs_extra);
  assign op_ready  = !stall_reg;

  // operand routing into the alu
  wire dest_file = is_file && (x_dest || is_bclr);
  assign alu_bus.op      = x_op;
  assign alu_bus.a       = (is_asr || is_bclr) ? file_rdata : acc_reg;
  assign alu_bus.b       = is_imm ? x_lit : file_rdata;
  assign alu_bus.cin     = (x_op == cau_pkg::op_add_with_carry_file) && c_reg;
  assign alu_bus.bit_idx = x_bit;

  // pointer sum, 16-bit truncation gives the wrap-around
  wire [15:0] ptr_cur = x_psel ? ptr1_reg : ptr0_reg;
  wire [15:0] ptr_sum = 16'(ptr_cur + cau_pkg::sext_offset(x_lit[5:0]));

  // next values
  wire [7:0]  acc_next  = (exec && !is_ptr && !dest_file) ? alu_bus.result : acc_reg;
  wire        upd_c     = exec && (is_add || is_asr);
  wire        upd_dc    = exec && is_add;
  wire        upd_z     = exec && (is_add || is_asr || is_and);
  wire        c_next    = upd_c  ? alu_bus.carry : c_reg;
  wire        dc_next   = upd_dc ? alu_bus.half  : dc_reg;
  wire        z_next    = upd_z  ? alu_bus.zero  : z_reg;
  wire [15:0] ptr0_next = (exec && is_ptr && !x_psel) ? ptr_sum : ptr0_reg;
  wire [15:0] ptr1_next = (exec && is_ptr &&  x_psel) ? ptr_sum : ptr1_reg;

  // architectural state
  always_ff @(posedge clock) begin
    if (srst) begin
      acc_reg  <= cau_pkg::ACC_RST;
      ptr0_reg <= cau_pkg::PTR_RST;
      ptr1_reg <= cau_pkg::PTR_RST;
      c_reg    <= 1'b0;
      dc_reg   <= 1'b0;
      z_reg    <= 1'b0;
    end else begin
      acc_reg  <= acc_next;
      ptr0_reg <= ptr0_next;
      ptr1_reg <= ptr1_next;
      c_reg    <= c_next;
      dc_reg   <= dc_next;
      z_reg    <= z_next;
    end
  end

  // file write port and completion pulse
  always_ff @(posedge clock) begin
    if (srst) begin
      we_reg    <= 1'b0;
      waddr_reg <= 7'h00;
      wdata_reg <= cau_pkg::ZERO_BYTE;
      done_reg  <= 1'b0;
    end else begin
      we_reg    <= exec && dest_file;
      waddr_reg <= x_addr;
      wdata_reg <= alu_bus.result;
      done_reg  <= exec;
    end
  end

  // hold fields across the extra cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      stall_reg     <= 1'b0;
      hold_op_reg   <= cau_pkg::op_and_immediate;
      hold_lit_reg  <= cau_pkg::ZERO_BYTE;
      hold_addr_reg <= 7'h00;
      hold_bit_reg  <= 3'h0;
      hold_dest_reg <= 1'b0;
      hold_psel_reg <= 1'b0;
    end else begin
      stall_reg     <= needs_extra;
      if (needs_extra) begin
        hold_op_reg   <= op_code;
        hold_lit_reg  <= op_literal;
        hold_addr_reg <= op_file_addr;
        hold_bit_reg  <= op_bit_idx;
        hold_dest_reg <= op_dest_sel;
        hold_psel_reg <= op_ptr_sel;
      end
    end
  end

  // outputs
  assign file_rd_addr           = x_addr;
  assign file_we                = we_reg;
  assign file_waddr             = waddr_reg;
  assign file_wdata             = wdata_reg;
  assign accum                  = acc_reg;
  assign indirect_pointer0      = ptr0_reg;
  assign indirect_pointer1      = ptr1_reg;
  assign carry_bit              = c_reg;
  assign half_byte_overflow_bit = dc_reg;
  assign zero_bit               = z_reg;
  assign op_done                = done_reg;

  // checks; low-nibble sum kept apart from the alu unit for the half carry check
  wire [4:0] nib_chk = {1'b0, acc_reg[3:0]} + {1'b0, alu_bus.b[3:0]} + {4'h0, alu_bus.cin};

  property p_ptr_add;
    @(posedge clock) disable iff (srst)
    exec && is_ptr && !x_psel |=> ptr0_reg == $past(ptr_sum) && ptr1_reg == $past(ptr1_reg);
  endproperty
  a_ptr_add: assert property (p_ptr_add) else $error("pointer add wrong");

  property p_ptr_wrap;
    @(posedge clock) disable iff (srst)
    exec && is_ptr && !x_psel && ptr0_reg == 16'hFFFF && x_lit[5:0] == 6'h01 |=> ptr0_reg == 16'h0000;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

  property p_and_imm;
    @(posedge clock) disable iff (srst)
    exec && x_op == cau_pkg::op_and_immediate |=>
      acc_reg == ($past(acc_reg) & $past(x_lit)) && c_reg == $past(c_reg) && dc_reg == $past(dc_reg);
  endproperty
  a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

  property p_add_imm;
    @(posedge clock) disable iff (srst)
    exec && x_op == cau_pkg::op_add_immediate |=>
      {c_reg, acc_reg} == 9'({1'b0, $past(acc_reg)} + {1'b0, $past(x_lit)});
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");

  property p_dest_file;
    @(posedge clock) disable iff (srst)
    exec && is_file && x_dest |=> file_we && file_waddr == $past(x_addr) && acc_reg == $past(acc_reg);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

  property p_and_file;
    @(posedge clock) disable iff (srst)
    exec && x_op == cau_pkg::op_and_with_file && !x_dest |=>
      acc_reg == ($past(acc_reg) & $past(file_rdata)) && !file_we;
  endproperty
  a_and_file: assert property (p_and_file) else $error("and with file wrong");

  property p_add_file;
    @(posedge clock) disable iff (srst)
    exec && x_op == cau_pkg::op_add_with_file && x_dest |=>
      {c_reg, file_wdata} == 9'({1'b0, $past(acc_reg)} + {1'b0, $past(file_rdata)});
  endproperty
  a_add_file: assert property (p_add_file) else $error("add with file wrong");

  property p_asr;
    @(posedge clock) disable iff (srst)
    exec && is_asr && x_dest |=> file_wdata == {$past(file_rdata[7]), $past(file_rdata[7:1])}
      && c_reg == $past(file_rdata[0]);
  endproperty
  a_asr: assert property (p_asr) else $error("arithmetic shift wrong");

  property p_addc;
    @(posedge clock) disable iff (srst)
    exec && x_op == cau_pkg::op_add_with_carry_file && !x_dest |=>
      {c_reg, acc_reg} == 9'({1'b0, $past(acc_reg)} + {1'b0, $past(file_rdata)} + {8'h00, $past(c_reg)});
  endproperty
  a_addc: assert property (p_addc) else $error("add with carry wrong");

  property p_bclr;
    @(posedge clock) disable iff (srst)
    exec && is_bclr |=> file_we && file_wdata[$past(x_bit)] == 1'b0
      && (file_wdata | (8'h01 << $past(x_bit))) == ($past(file_rdata) | (8'h01 << $past(x_bit)))
      && z_reg == $past(z_reg) && c_reg == $past(c_reg) && dc_reg == $past(dc_reg);
  endproperty
  a_bclr: assert property (p_bclr) else $error("bit clear wrong");

  property p_extra;
    @(posedge clock) disable iff (srst)
    needs_extra |=> !op_ready && !op_done ##1 op_done && op_ready;
  endproperty
  a_extra: assert property (p_extra) else $error("extra cycle missing");

  property p_flags;
    @(posedge clock) disable iff (srst)
    exec && is_add && !x_dest |=> z_reg == (acc_reg == 8'h00)
      && dc_reg == $past(nib_chk[4]);
  endproperty
  a_flags: assert property (p_flags) else $error("add flags wrong");

  c_extra: cover property (@(posedge clock) disable iff (srst) needs_extra ##2 op_done);
  c_wrap:  cover property (@(posedge clock) disable iff (srst) exec && is_ptr && ptr_sum < ptr_cur);
  c_carry: cover property (@(posedge clock) disable iff (srst) exec && is_add && alu_bus.carry && alu_bus.zero);

endmodule : cau_alu_top

/* File: sim/cau_mem_model.sv */
// Purpose: data memory on the far side of the alu subset, 128 bytes
// Assumes: read is combinational from the read address, write lands at the clock edge
// Notes:   bench preloads the array by hierarchical access before reset ends
`timescale 1ns/1ps
module cau_mem_model (
  // clock
  input  wire logic       clock,
  // read side
  input  wire logic [6:0] file_rd_addr,
  output logic [7:0]      file_rdata,
  // write side
  input  wire logic       file_we,
  input  wire logic [6:0] file_waddr,
  input  wire logic [7:0] file_wdata
);
  logic [7:0] mem [0:127];

  // combinational read, same cycle as the address
  assign file_rdata = mem[file_rd_addr];

  // write pulse applied at its own edge, no bypass to the read port
  always @(posedge clock) begin
    if (file_we === 1'b1) begin
      mem[file_waddr] <= file_wdata;
    end
  end
endmodule : cau_mem_model

/* File: sim/tb.sv */
// Purpose: self-checking bench for the alu instruction subset against an integer model
// Assumes: one instruction in flight, an idle cycle after each so writes land before reads
// Notes:   random operands from a fixed seed, addresses 0..7 to hit the indirect operands
`timescale 1ns/1ps
module tb;
  logic                clock, srst, op_valid, op_dest_sel, op_ptr_sel;
  cau_pkg::cau_op_type op_code;
  logic [7:0]          op_literal;
  logic [6:0]          op_file_addr;
  logic [2:0]          op_bit_idx;
  wire logic           op_ready, file_we, carry_bit, half_byte_overflow_bit, zero_bit, op_done;
  wire logic [6:0]     file_rd_addr, file_waddr;
  wire logic [7:0]     file_rdata, file_wdata, accum;
  wire logic [15:0]    indirect_pointer0, indirect_pointer1;
  int                  acc_m, c_m, dc_m, z_m, miscompares, samples_checked, k, v;
  int                  ptr_m [2];
  int                  mem_m [128];

  cau_alu_top i_cau_alu_top (.clock(clock), .srst(srst), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_literal(op_literal), .op_file_addr(op_file_addr), .op_bit_idx(op_bit_idx),
    .op_dest_sel(op_dest_sel), .op_ptr_sel(op_ptr_sel), .file_rd_addr(file_rd_addr),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .accum(accum), .indirect_pointer0(indirect_pointer0), .indirect_pointer1(indirect_pointer1),
    .carry_bit(carry_bit), .half_byte_overflow_bit(half_byte_overflow_bit), .zero_bit(zero_bit),
    .op_done(op_done));

  cau_mem_model i_cau_mem_model (.clock(clock), .file_rd_addr(file_rd_addr), .file_rdata(file_rdata),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata));

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // one comparison, counted, reported at once
  task check(input string what, input int exp_v, input logic [15:0] got);
    samples_checked++;
    if (got !== 16'(exp_v)) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp_v, got);
    end
  endtask : check

  // counts, verdict and end of run
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // issue one instruction, step the model, compare latency and state
  task run_op(input cau_pkg::cau_op_type op, input int lit, input int addr, input int bidx,
              input int dsel, input int psel);
    int f, b, r, s, ci, lat, n;
    f = mem_m[addr];
    b = (op == cau_pkg::op_add_immediate || op == cau_pkg::op_and_immediate) ? lit : f;
    r = 0;
    lat = (op >= cau_pkg::op_and_with_file && addr < 2 && ptr_m[addr] >= 32768) ? 2 : 1;
    @(posedge clock);
    op_valid     <= 1'b1;
    op_code      <= op;
    op_literal   <= 8'(lit);
    op_file_addr <= 7'(addr);
    op_bit_idx   <= 3'(bidx);
    op_dest_sel  <= 1'(dsel);
    op_ptr_sel   <= 1'(psel);
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    n = 1;
    while (op_done !== 1'b1 && n < 6) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("latency", lat, 16'(n));
    case (op)
      cau_pkg::op_pointer_offset_add:
        ptr_m[psel] = (ptr_m[psel] + (((lit & 63) >= 32) ? (lit & 63) - 64 : (lit & 63))) & 65535;
      cau_pkg::op_and_immediate, cau_pkg::op_and_with_file: begin
        r = acc_m & b;
        z_m = (r == 0);
      end
      cau_pkg::op_arith_shift_right: begin
        r = (f >> 1) | (f & 128);
        c_m = f & 1;
        z_m = (r == 0);
      end
      cau_pkg::op_bit_clear_in_file: r = f & ~(1 << bidx) & 255;
      default: begin
        ci = (op == cau_pkg::op_add_with_carry_file) ? c_m : 0;
        s = acc_m + b + ci;
        dc_m = ((acc_m & 15) + (b & 15) + ci) > 15;
        c_m = s > 255;
        r = s & 255;
        z_m = (r == 0);
      end
    endcase
    if (op == cau_pkg::op_and_immediate || op == cau_pkg::op_add_immediate) acc_m = r;
    else if (op != cau_pkg::op_pointer_offset_add && op != cau_pkg::op_bit_clear_in_file && dsel == 0) acc_m = r;
    else if (op != cau_pkg::op_pointer_offset_add) mem_m[addr] = r;
    // let the write pulse land in memory before comparing
    @(posedge clock);
    #1;
    check("accum", acc_m, {8'h00, accum});
    check("file", mem_m[addr], {8'h00, i_cau_mem_model.mem[addr]});
    check("pointer0", ptr_m[0], indirect_pointer0);
    check("pointer1", ptr_m[1], indirect_pointer1);
    check("carry", c_m, {15'h0000, carry_bit});
    check("half carry", dc_m, {15'h0000, half_byte_overflow_bit});
    check("zero", z_m, {15'h0000, zero_bit});
  endtask : run_op

  // main sequence
  initial begin
    srst = 1'b1;
    op_valid = 1'b0;
    op_code = cau_pkg::op_and_immediate;
    op_literal = 8'h00;
    op_file_addr = 7'h00;
    op_bit_idx = 3'h0;
    op_dest_sel = 1'b0;
    op_ptr_sel = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    acc_m = 0;
    c_m = 0;
    dc_m = 0;
    z_m = 0;
    ptr_m[0] = 0;
    ptr_m[1] = 0;
    v = $urandom(91);
    for (k = 0; k < 128; k++) begin
      v = $urandom_range(0, 255);
      mem_m[k] = v;
      i_cau_mem_model.mem[k] = 8'(v);
    end
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check("ready after reset", 1, {15'h0000, op_ready});
    run_op(cau_pkg::op_add_immediate, 8'h0B, 2, 0, 0, 0);
    run_op(cau_pkg::op_add_immediate, 8'h05, 2, 0, 0, 0);
    run_op(cau_pkg::op_add_immediate, 8'hF0, 2, 0, 0, 0);
    run_op(cau_pkg::op_add_immediate, 8'h3C, 2, 0, 0, 0);
    run_op(cau_pkg::op_and_immediate, 8'h0F, 2, 0, 0, 0);
    $display("test immediates done");
    run_op(cau_pkg::op_pointer_offset_add, 8'h20, 2, 0, 0, 0);
    run_op(cau_pkg::op_pointer_offset_add, 8'h1F, 2, 0, 0, 0);
    run_op(cau_pkg::op_pointer_offset_add, 8'h01, 2, 0, 0, 0);
    run_op(cau_pkg::op_pointer_offset_add, 8'h1F, 2, 0, 0, 1);
    run_op(cau_pkg::op_pointer_offset_add, 8'h20, 2, 0, 0, 0);
    $display("test pointer add done");
    run_op(cau_pkg::op_and_with_file, 0, 0, 0, 1, 0);
    run_op(cau_pkg::op_add_with_file, 0, 1, 0, 1, 0);
    for (k = 6; k < 16; k++)
      run_op(cau_pkg::cau_op_type'(k / 2), 0, k, 3, k % 2, 0);
    for (k = 0; k < 8; k++) run_op(cau_pkg::op_bit_clear_in_file, 0, 4, k, 1, 0);
    $display("test file ops done");
    repeat (300) run_op(cau_pkg::cau_op_type'($urandom_range(0, 7)), $urandom_range(0, 255),
      $urandom_range(0, 7), $urandom_range(0, 7), $urandom_range(0, 1), $urandom_range(0, 1));
    $display("test random done");
    conclude();
  end

  // watchdog sized well above the roughly 1000 cycles the tests need
  initial begin
    repeat (8000) @(posedge clock);
    miscompares++;
    $display("MISMATCH watchdog expected finish seen timeout");
    conclude();
  end
endmodule : tb
